/* rtl/mic_interrupt_control.sv */
// Functional notes
// - three external pins each raise their own interrupt request
// - internal timer, protection, time base, detector, eeprom and adc requests accepted
// - four primary control registers hold flags, enables and global enable
// - four shared-group registers hold timer match and eeprom flags and enables
// - edge select register picks the trigger edge of each pin
// - every source owns an enable bit and a request flag
// - third pin field bits 5:4: off, rising, falling, both
// - second pin field bits 3:2: off, rising, falling, both
// - first pin field bits 1:0: off, rising, falling, both
// - control a bit 6 is overcurrent channel a request flag
// - control a bit 5 is overvoltage request flag
// - control a bit 4 is overcurrent channel b request flag
// - control a bit 3 enables overcurrent channel a
// - control a bit 2 enables overvoltage interrupt
// - control a bit 1 enables overcurrent channel b
// - a serviced request suspends the main program for the source
// - unimplemented bits always read zero
// - all registers are readable and writable in data memory
// - triggers set flags regardless of enable bits, except control c group flags, gated by member enables
// - only enabled pending requests branch to their vector
// - on entry the core stacks the counter and loads the vector
// - global enable cleared blocks every interrupt
module mic_interrupt_control (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// data memory access
	input  wire mic_pkg::mic_sfr_req_s sfrReq,
	output logic      [7:0]           sfrRdata,
	// external interrupt pins
	input  wire logic [2:0]           extIrqPin,
	// internal event pulses
	input  wire mic_pkg::mic_evt_s    srcEvt,
	// core sequencer
	output logic                      irqRequest,
	output logic      [11:0]          irqVector,
	input  wire logic                 irqAck,
	input  wire logic                 irqReturn
);

	// decoded register index for an address, hit flag in bit 4
	function automatic logic [4:0] decodeAddr(input logic [7:0] a);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < mic_pkg::NUM_REGS; i++) begin
			if (a == mic_pkg::REG_ADDR[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : decodeAddr

	// edge detection against the selected trigger edge
	function automatic logic edgeHit(input logic [1:0] mode, input logic prev, input logic cur);
		logic h;
		case (mode)
			mic_pkg::EDGE_RISE: h = ~prev & cur;
			mic_pkg::EDGE_FALL: h = prev & ~cur;
			mic_pkg::EDGE_BOTH: h = prev ^ cur;
			default:            h = 1'b0;
		endcase
		return h;
	endfunction : edgeHit

	logic [7:0]  regs_reg  [0:mic_pkg::NUM_REGS-1];
	logic [7:0]  regs_next [0:mic_pkg::NUM_REGS-1];
	logic [7:0]  setVec    [0:mic_pkg::NUM_REGS-1];
	logic [7:0]  clrVec    [0:mic_pkg::NUM_REGS-1];
	logic [2:0]  pinPrev_reg;
	logic [2:0]  pinHit;
	logic [3:0]  groupAny;
	logic [3:0]  srcIdx_reg;
	logic [3:0]  srcIdx_next;
	logic        irqRequest_reg;
	logic        irqRequest_next;
	logic [11:0] irqVector_reg;
	logic [11:0] irqVector_next;
	logic [7:0]  sfrRdata_reg;
	logic [7:0]  sfrRdata_next;
	logic [4:0]  wrDec;
	logic [4:0]  rdDec;
	logic [mic_pkg::NUM_SRC-1:0] pendNext;

	// per-pin edge detection; pins with field 00 never trigger
	generate
		for (genvar p = 0; p < 3; p++) begin : gPin
			assign pinHit[p] = edgeHit(regs_reg[mic_pkg::IDX_EDGE][2*p +: 2], pinPrev_reg[p], extIrqPin[p]);
		end
	endgenerate

	// shared group request: any member flag whose member enable is set
	generate
		for (genvar g = 0; g < 4; g++) begin : gGroup
			assign groupAny[g] = |(regs_reg[mic_pkg::IDX_GA + 4'(g)][6:4]
				& regs_reg[mic_pkg::IDX_GA + 4'(g)][2:0]);
		end
	endgenerate

	assign wrDec = decodeAddr(sfrReq.addr);
	assign rdDec = wrDec;

	// hardware set vectors; flags set whatever the enables say, except control c group flags, gated by member enables
	always_comb begin
		for (int r = 0; r < mic_pkg::NUM_REGS; r++) begin
			setVec[r] = 8'h00;
		end
		setVec[mic_pkg::IDX_CA][mic_pkg::OCA_FLAG_BIT] = srcEvt.overcurrentA;
		setVec[mic_pkg::IDX_CA][mic_pkg::OVP_FLAG_BIT] = srcEvt.overvoltage;
		setVec[mic_pkg::IDX_CA][mic_pkg::OCB_FLAG_BIT] = srcEvt.overcurrentB;
		setVec[mic_pkg::IDX_CB][mic_pkg::PIN_FLAG_LSB +: 3] = pinHit;
		setVec[mic_pkg::IDX_CB][mic_pkg::UVP_FLAG_BIT] = srcEvt.undervoltage;
		setVec[mic_pkg::IDX_CC][mic_pkg::SHARED_F_LSB +: 4] = groupAny;
		setVec[mic_pkg::IDX_CD][mic_pkg::ADC_FLAG_BIT] = srcEvt.conversionDone;
		setVec[mic_pkg::IDX_CD][mic_pkg::TB0_FLAG_BIT] = srcEvt.timebase0;
		setVec[mic_pkg::IDX_CD][mic_pkg::TB1_FLAG_BIT] = srcEvt.timebase1;
		setVec[mic_pkg::IDX_CD][mic_pkg::LVD_FLAG_BIT] = srcEvt.lowSupply;
		for (int g = 0; g < 4; g++) begin
			setVec[mic_pkg::IDX_GA + 4'(g)][mic_pkg::TPM_FLAG_BIT] = srcEvt.timerPeriodMatch[g];
			setVec[mic_pkg::IDX_GA + 4'(g)][mic_pkg::TCM_FLAG_BIT] = srcEvt.timerCompareMatch[g];
		end
		setVec[mic_pkg::IDX_GA][mic_pkg::EEP_FLAG_BIT] = srcEvt.eepromDone;
	end

	// flag of the serviced source clears on entry, as does the global enable
	always_comb begin
		for (int r = 0; r < mic_pkg::NUM_REGS; r++) begin
			clrVec[r] = 8'h00;
		end
		if (irqAck && irqRequest_reg) begin
			clrVec[mic_pkg::SRC_REG[srcIdx_reg]][mic_pkg::SRC_FLAG[srcIdx_reg]] = 1'b1;
			clrVec[mic_pkg::IDX_CA][mic_pkg::GLOBAL_EN_BIT] = 1'b1; // nesting blocked until return
		end
	end

	// register next state: write, then service clear, then hardware set
	always_comb begin
		for (int r = 0; r < mic_pkg::NUM_REGS; r++) begin
			regs_next[r] = regs_reg[r];
			if (sfrReq.wr && wrDec[4] && wrDec[3:0] == 4'(r)) begin
				regs_next[r] = sfrReq.wdata & mic_pkg::REG_MASK[r];
			end
			regs_next[r] = regs_next[r] & ~clrVec[r];
			// set after clear so an event in the clear cycle is kept
			regs_next[r] = (regs_next[r] | setVec[r]) & mic_pkg::REG_MASK[r];
		end
		if (irqReturn) begin
			regs_next[mic_pkg::IDX_CA][mic_pkg::GLOBAL_EN_BIT] = 1'b1;
		end
	end

	// pending and priority choice from next state keeps the output in step with flags
	always_comb begin
		pendNext = '0;
		srcIdx_next = 4'h0;
		for (int s = 0; s < mic_pkg::NUM_SRC; s++) begin
			pendNext[s] = regs_next[mic_pkg::SRC_REG[s]][mic_pkg::SRC_FLAG[s]]
				& regs_next[mic_pkg::SRC_REG[s]][mic_pkg::SRC_EN[s]];
		end
		for (int s = mic_pkg::NUM_SRC - 1; s >= 0; s--) begin
			if (pendNext[s]) begin
				srcIdx_next = 4'(s); // lowest index wins
			end
		end
		irqRequest_next = regs_next[mic_pkg::IDX_CA][mic_pkg::GLOBAL_EN_BIT] & (|pendNext);
		irqVector_next = mic_pkg::VEC_BASE + 12'(srcIdx_next * mic_pkg::VEC_STEP);
	end

	// read data, one cycle after the read strobe; unmapped reads zero
	always_comb begin
		sfrRdata_next = sfrRdata_reg;
		if (sfrReq.rd) begin
			sfrRdata_next = rdDec[4] ? regs_reg[rdDec[3:0]] : 8'h00;
		end
	end

	// state registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int r = 0; r < mic_pkg::NUM_REGS; r++) begin
				regs_reg[r] <= mic_pkg::REG_RESET;
			end
			pinPrev_reg    <= 3'h0;
			srcIdx_reg     <= 4'h0;
			irqRequest_reg <= 1'b0;
			irqVector_reg  <= 12'h000;
			sfrRdata_reg   <= 8'h00;
		end else begin
			for (int r = 0; r < mic_pkg::NUM_REGS; r++) begin
				regs_reg[r] <= regs_next[r];
			end
			pinPrev_reg    <= extIrqPin;
			srcIdx_reg     <= srcIdx_next;
			irqRequest_reg <= irqRequest_next;
			irqVector_reg  <= irqVector_next;
			sfrRdata_reg   <= sfrRdata_next;
		end
	end

	assign irqRequest = irqRequest_reg;
	assign irqVector  = irqVector_reg;
	assign sfrRdata   = sfrRdata_reg;

endmodule : mic_interrupt_control

/* rtl/mic_pkg.sv */
package mic_pkg;

	// register indices inside the special-purpose data memory window
	localparam int NUM_REGS = 9;
	localparam logic [3:0] IDX_EDGE = 4'h0;
	localparam logic [3:0] IDX_CA   = 4'h1;
	localparam logic [3:0] IDX_CB   = 4'h2;
	localparam logic [3:0] IDX_CC   = 4'h3;
	localparam logic [3:0] IDX_CD   = 4'h4;
	localparam logic [3:0] IDX_GA   = 4'h5;

	// data memory addresses of the nine registers
	localparam logic [7:0] REG_ADDR [0:NUM_REGS-1] = '{
		8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28};

	// implemented bits; everything else reads zero
	localparam logic [7:0] REG_MASK [0:NUM_REGS-1] = '{
		8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h33, 8'h33, 8'h33};

	localparam logic [7:0] REG_RESET = 8'h00;

	// bit positions
	localparam int GLOBAL_EN_BIT = 0;
	localparam int OCA_FLAG_BIT  = 6;
	localparam int OVP_FLAG_BIT  = 5;
	localparam int OCB_FLAG_BIT  = 4;
	localparam int UVP_FLAG_BIT  = 4;
	localparam int PIN_FLAG_LSB  = 5;
	localparam int SHARED_F_LSB  = 4;
	localparam int ADC_FLAG_BIT  = 4;
	localparam int TB0_FLAG_BIT  = 5;
	localparam int TB1_FLAG_BIT  = 6;
	localparam int LVD_FLAG_BIT  = 7;
	localparam int TPM_FLAG_BIT  = 4;
	localparam int TCM_FLAG_BIT  = 5;
	localparam int EEP_FLAG_BIT  = 6;

	// edge field encoding
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// primary sources in priority order: register, flag bit, enable bit
	localparam int NUM_SRC = 15;
	localparam logic [3:0] SRC_REG [0:NUM_SRC-1] = '{
		4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h2,
		4'h3, 4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h4};
	localparam logic [2:0] SRC_FLAG [0:NUM_SRC-1] = '{
		3'h5, 3'h6, 3'h7, 3'h6, 3'h5, 3'h4, 3'h4,
		3'h4, 3'h5, 3'h6, 3'h7, 3'h5, 3'h6, 3'h4, 3'h7};
	localparam logic [2:0] SRC_EN [0:NUM_SRC-1] = '{
		3'h1, 3'h2, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0,
		3'h0, 3'h1, 3'h2, 3'h3, 3'h1, 3'h2, 3'h0, 3'h3};

	// vector address = base + index * step
	localparam logic [11:0] VEC_BASE = 12'h004;
	localparam logic [11:0] VEC_STEP = 12'h004;

	// data memory access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mic_sfr_req_s;

	// single-cycle event pulses from internal sources
	typedef struct packed {
		logic       overcurrentA;
		logic       overcurrentB;
		logic       overvoltage;
		logic       undervoltage;
		logic       timebase0;
		logic       timebase1;
		logic       lowSupply;
		logic       conversionDone;
		logic       eepromDone;
		logic [3:0] timerPeriodMatch;
		logic [3:0] timerCompareMatch;
	} mic_evt_s;

endpackage : mic_pkg

/* bench/mic_interrupt_control_sva.sv */
module mic_interrupt_control_sva (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  rst,
	// watched ports
	input wire mic_pkg::mic_sfr_req_s sfrReq,
	input wire logic [7:0]            sfrRdata,
	input wire logic [2:0]            extIrqPin,
	input wire mic_pkg::mic_evt_s     srcEvt,
	input wire logic                  irqRequest,
	input wire logic [11:0]           irqVector,
	input wire logic                  irqAck,
	input wire logic                  irqReturn
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// arm overvoltage with global on, then fire it
	sequence s_ovp_armed;
		sfrReq.wr && sfrReq.addr == 8'h21 && sfrReq.wdata == 8'h05 && !irqAck && !irqReturn;
	endsequence
	sequence s_ovp_fire;
		srcEvt.overvoltage && !sfrReq.wr && !irqAck;
	endsequence
	AST_OVP_RAISE: assert property (s_ovp_armed ##1 s_ovp_fire |=> irqRequest)
		else $error("overvoltage event raised no request");
	AST_ACK_DROPS: assert property (irqAck && irqRequest && !irqReturn && !sfrReq.wr |=> !irqRequest)
		else $error("request stayed after acknowledge");
	AST_GLOBAL_OFF: assert property (sfrReq.wr && sfrReq.addr == 8'h21 && !sfrReq.wdata[0] && !irqReturn
		|=> !irqRequest)
		else $error("request with global enable cleared");
	AST_CA_RSVD: assert property (sfrReq.rd && sfrReq.addr == 8'h21 |=> !sfrRdata[7])
		else $error("control a bit 7 not zero");
	AST_EDGE_RSVD: assert property (sfrReq.rd && sfrReq.addr == 8'h20 |=> sfrRdata[7:6] == 2'h0)
		else $error("edge select top bits not zero");
	AST_GROUP_RSVD: assert property (sfrReq.rd && sfrReq.addr inside {[8'h26:8'h28]}
		|=> (sfrRdata & 8'hCC) == 8'h00)
		else $error("group register unused bits not zero");
	AST_UNMAPPED: assert property (sfrReq.rd && !(sfrReq.addr inside {[8'h20:8'h28]}) |=> sfrRdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!sfrReq.rd |=> $stable(sfrRdata))
		else $error("read data changed without a read");
endmodule : mic_interrupt_control_sva

bind mic_interrupt_control mic_interrupt_control_sva i_mic_interrupt_control_sva (.clk(clk), .rst(rst),
	.sfrReq(sfrReq), .sfrRdata(sfrRdata), .extIrqPin(extIrqPin), .srcEvt(srcEvt), .irqRequest(irqRequest),
	.irqVector(irqVector), .irqAck(irqAck), .irqReturn(irqReturn));

/* bench/mic_core_model.sv */
module mic_core_model (
	// clock, reset, request side
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         irqRequest,
	input wire logic [11:0]  irqVector,
	input wire logic         enable,
	// answers
	output logic             irqAck,
	output logic             irqReturn,
	output logic [11:0]      takenVector
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt;
	logic       busy;
	// falling edge so the design samples a settled ack
	always @(negedge clk or posedge rst) begin
		if (rst) begin
			{irqAck, irqReturn, busy, cnt, takenVector} <= '0;
		end else begin
			irqAck <= 1'b0;
			irqReturn <= 1'b0;
			if (busy) begin
				cnt <= cnt + 3'h1;
				busy <= cnt != 3'h3;
				irqReturn <= cnt == 3'h3;
			end else if (enable && irqRequest) begin
				irqAck <= 1'b1;
				takenVector <= irqVector;
				busy <= 1'b1;
				cnt <= 3'h0;
			end
		end
	end
endmodule : mic_core_model

/* bench/mic_interrupt_control_tb_top.sv */
module mic_interrupt_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  coreOn = 1'b0;
	logic [2:0]            extIrqPin = 3'h0;
	mic_pkg::mic_sfr_req_s sfrReq = '0;
	mic_pkg::mic_evt_s     srcEvt = '0;
	logic [7:0]            sfrRdata, v;
	logic                  irqRequest, irqAck, irqReturn;
	logic [11:0]           irqVector, takenVector;
	int                    bad_count = 0, checks_done = 0, cyc = 0;
	always #12.5 clk = ~clk;
	mic_interrupt_control i_mic_interrupt_control (.clk(clk), .rst(rst), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
		.extIrqPin(extIrqPin), .srcEvt(srcEvt), .irqRequest(irqRequest), .irqVector(irqVector),
		.irqAck(irqAck), .irqReturn(irqReturn));
	mic_core_model i_mic_core_model (.clk(clk), .rst(rst), .irqRequest(irqRequest), .irqVector(irqVector),
		.enable(coreOn), .irqAck(irqAck), .irqReturn(irqReturn), .takenVector(takenVector));
	task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] s);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	// bus strobes last one cycle, driven off the sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk) sfrReq <= '{1'b1, 1'b0, a, d};
		@(negedge clk) sfrReq <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge clk) sfrReq <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk) sfrReq <= '0;
		v = sfrRdata;
	endtask : rd
	task automatic pulse(input mic_pkg::mic_evt_s e);
		@(negedge clk) srcEvt <= e;
		@(negedge clk) srcEvt <= '0;
	endtask : pulse
	task automatic t_regs;
		for (int i = 0; i < mic_pkg::NUM_REGS; i++) begin
			rd(mic_pkg::REG_ADDR[i]);
			cmp("reset value", 8'h00, v);
			wr(mic_pkg::REG_ADDR[i], 8'hFF);
			rd(mic_pkg::REG_ADDR[i]);
			cmp("written bits", mic_pkg::REG_MASK[i], v);
			wr(mic_pkg::REG_ADDR[i], 8'h00);
		end
		wr(8'h23, 8'h00);
		rd(8'h30);
		cmp("unmapped read", 8'h00, v);
		$display("test regs done");
	endtask : t_regs
	task automatic t_edges;
		for (int p = 0; p < 3; p++) for (int c = 0; c < 4; c++) begin
			wr(8'h20, 8'(c << (2 * p)));
			@(negedge clk) extIrqPin[p] <= 1'b1;
			rd(8'h22);
			cmp("rise flag", 12'(c % 2), 12'(v[5 + p]));
			wr(8'h22, 8'h00);
			@(negedge clk) extIrqPin[p] <= 1'b0;
			rd(8'h22);
			cmp("fall flag", 12'(c / 2), 12'(v[5 + p]));
			wr(8'h22, 8'h00);
		end
		$display("test edges done");
	endtask : t_edges
	task automatic t_prot;
		pulse(17'h1C000);
		rd(8'h21);
		cmp("flags while disabled", 8'h70, v);
		cmp("masked request", 1'b0, irqRequest);
		wr(8'h21, 8'h2E);
		cmp("global off", 1'b0, irqRequest);
		@(negedge clk) coreOn <= 1'b1;
		wr(8'h21, 8'h2F);
		repeat (10) @(negedge clk);
		cmp("overvoltage vector", mic_pkg::VEC_BASE + 12'h010, takenVector);
		pulse(17'h14000);
		repeat (20) @(negedge clk);
		cmp("second vector", mic_pkg::VEC_BASE + 12'h010, takenVector);
		rd(8'h21);
		cmp("flags serviced", 8'h0F, v);
		@(negedge clk) coreOn <= 1'b0;
		wr(8'h21, 8'h00);
		$display("test protection done");
	endtask : t_prot
	// internal sources not covered elsewhere, then an armed overvoltage seen on the outputs directly
	task automatic t_src;
		pulse(17'h03F08);
		rd(8'h22);
		cmp("undervoltage flag", 8'h10, v);
		rd(8'h24);
		cmp("ctrl d flags", 8'hF0, v);
		rd(8'h25);
		cmp("eeprom flag", 8'h40, v);
		rd(8'h28);
		cmp("compare match flag", 8'h20, v);
		wr(8'h22, 8'h00);
		wr(8'h24, 8'h00);
		wr(8'h25, 8'h00);
		wr(8'h28, 8'h00);
		// event lands the cycle right after the enabling write
		@(negedge clk) sfrReq <= '{1'b1, 1'b0, 8'h21, 8'h05};
		@(negedge clk) begin
			sfrReq <= '0;
			srcEvt <= 17'h04000;
		end
		@(negedge clk) srcEvt <= '0;
		cmp("armed request", 1'b1, irqRequest);
		cmp("armed vector", mic_pkg::VEC_BASE + 12'h010, irqVector);
		wr(8'h21, 8'h00);
		$display("test sources done");
	endtask : t_src
	task automatic t_shared;
		pulse(17'h00010);
		rd(8'h25);
		cmp("member flag", 8'h10, v);
		rd(8'h23);
		cmp("group idle", 8'h00, v);
		wr(8'h25, 8'h11);
		rd(8'h23);
		cmp("group set", 8'h10, v);
		wr(8'h23, 8'h11);
		@(negedge clk) coreOn <= 1'b1;
		wr(8'h21, 8'h01);
		repeat (10) @(negedge clk);
		@(negedge clk) coreOn <= 1'b0;
		cmp("group vector", mic_pkg::VEC_BASE + 12'h01C, takenVector);
		$display("test shared done");
	endtask : t_shared
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	// hang guard well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk) rst <= 1'b0;
		t_regs();
		t_edges();
		t_prot();
		t_src();
		t_shared();
		summarize();
	end
endmodule : mic_interrupt_control_tb_top
